// ==== verilog/bfs_supervisor.sv ====
// Breaker failure supervisor with AXI4-Lite registers
//
// What this block does
// R1: Current scheme: failure if current holds at or above threshold.
// R2: Position scheme: failure if no open indication before expiry.
// R3: Combined scheme: failure needs high current and no open indication.
// R4: Timer runs on after all triggers drop.
// R5: Expiry without open detection raises the failure trip.
// R6: Open detection per scheme stops the timer.
// R7: Open with triggers active enters rejected, no restart.
// R8: Rejected returns to standby once all triggers drop.
// R9: Lock rises with trip, holds until acknowledge.
// R10: Outside logic may block closing with the lock.
// R11: Trigger mode: all, external, current or no trip commands.
// R12: Enabled extra triggers ORed with mode triggers.
// R13: Supervision time exceeds relay, breaker, drop-off times and margin.
// R14: Upstream breaker owner opens it with the trip.
// R15: Timer counts ticks; reset clears state, trip, lock and loads the timer with 1.
// R16: Start on trigger rise in standby; no restart while busy.
`timescale 1ns/100ps
`include "bfs_params.svh"
module bfs_supervisor #(
   parameter int TICK_CYCLES = `BFS_TICK_CYCLES,
   parameter int N_EXTRA     = 3,
   parameter int CUR_W       = 16
) (
   input  wire logic               aclk,              // System clock
   input  wire logic               aresetn,           // Sync reset, low
   input  wire logic [7:0]         s_axi_awaddr,      // Write address
   input  wire logic               s_axi_awvalid,     // Write address valid
   output logic                    s_axi_awready,     // Write address ready
   input  wire logic [31:0]        s_axi_wdata,       // Write data
   input  wire logic [3:0]         s_axi_wstrb,       // Write byte strobes
   input  wire logic               s_axi_wvalid,      // Write data valid
   output logic                    s_axi_wready,      // Write data ready
   output logic [1:0]              s_axi_bresp,       // Write response
   output logic                    s_axi_bvalid,      // Write response valid
   input  wire logic               s_axi_bready,      // Write response ready
   input  wire logic [7:0]         s_axi_araddr,      // Read address
   input  wire logic               s_axi_arvalid,     // Read address valid
   output logic                    s_axi_arready,     // Read address ready
   output logic [31:0]             s_axi_rdata,       // Read data
   output logic [1:0]              s_axi_rresp,       // Read response
   output logic                    s_axi_rvalid,      // Read data valid
   input  wire logic               s_axi_rready,      // Read data ready
   input  wire logic               ext_trip_cmd,      // External trips
   input  wire logic               cur_trip_cmd,      // Current trips
   input  wire logic               oth_trip_cmd,      // Other trips
   input  wire logic [N_EXTRA-1:0] extra_trigger_input, // Extra triggers
   input  wire logic [CUR_W-1:0]   meas_current,      // Measured current
   input  wire logic               pos_open,          // Open indication
   output logic                    failure_trip,      // Backup trip
   output logic                    failure_lock,      // Latched lock
   output logic                    irq                // Interrupt, level
);

   // ****************
   // Registers
   // ****************
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   logic [6:0]           ctrl_r;
   logic [15:0]          time_r;
   logic [CUR_W-1:0]     thresh_r;
   logic [3:0]           irq_stat_r;
   logic [3:0]           irq_en_r;
   bfs_pkg::bfs_state_t  state_r;
   bfs_pkg::bfs_state_t  state_nxt;
   logic [15:0]          tcount_r;
   logic                 trig_prev_r;
   logic                 failure_trip_r;
   logic                 failure_lock_r;

   logic                 aw_held_r;
   logic [7:0]           aw_addr_r;
   logic                 w_held_r;
   logic [31:0]          w_data_r;
   logic [3:0]           w_strb_r;

   // Byte-lane merge honouring write strobes
   function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return res;
   endfunction

   // Address decode, shared by read and write paths
   function automatic logic addr_known(input logic [7:0] a);
      case (a)
         `BFS_OFF_CTRL, `BFS_OFF_TIME, `BFS_OFF_THRESH, `BFS_OFF_STATUS,
         `BFS_OFF_ACK, `BFS_OFF_IRQ_STAT, `BFS_OFF_IRQ_CLR,
         `BFS_OFF_IRQ_EN: addr_known = 1'b1;
         default: addr_known = 1'b0;
      endcase
   endfunction

   // ****************
   // AXI4-Lite write channel
   // ****************
   logic        wr_go;
   logic [7:0]  wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;

   assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
   assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
   assign wr_data = w_held_r ? w_data_r : s_axi_wdata;
   assign wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
   assign wr_go   = (aw_held_r || (s_axi_awvalid && s_axi_awready))
                    && (w_held_r || (s_axi_wvalid && s_axi_wready));

   always_ff @(posedge aclk) begin
      if (!aresetn || wr_go) begin
         aw_held_r <= 1'b0;
         aw_addr_r <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_r <= 1'b1;
         aw_addr_r <= s_axi_awaddr;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || wr_go) begin
         w_held_r <= 1'b0;
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_r <= 1'b1;
         w_data_r <= s_axi_wdata;
         w_strb_r <= s_axi_wstrb;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= addr_known(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   logic wr_ctrl;
   logic wr_ack;
   logic wr_clr;
   assign wr_ctrl = wr_go && wr_addr == `BFS_OFF_CTRL;
   assign wr_ack  = wr_go && wr_addr == `BFS_OFF_ACK && wr_strb[0] && wr_data[0];
   assign wr_clr  = wr_go && wr_addr == `BFS_OFF_IRQ_CLR && wr_strb[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= `BFS_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= 7'(strb_merge({25'h0, ctrl_r}, wr_data, wr_strb));
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         time_r   <= `BFS_TIME_RST;
         thresh_r <= CUR_W'(`BFS_THRESH_RST);
         irq_en_r <= `BFS_IRQ_EN_RST;
      end else if (wr_go) begin
         if (wr_addr == `BFS_OFF_TIME) begin
            time_r <= 16'(strb_merge({16'h0, time_r}, wr_data, wr_strb));
         end
         if (wr_addr == `BFS_OFF_THRESH) begin
            thresh_r <= CUR_W'(strb_merge(32'(thresh_r), wr_data, wr_strb));
         end
         if (wr_addr == `BFS_OFF_IRQ_EN) begin
            irq_en_r <= 4'(strb_merge({28'h0, irq_en_r}, wr_data, wr_strb));
         end
      end
   end

   // ****************
   // Trigger selection
   // ****************
   bfs_pkg::bfs_scheme_t scheme;
   bfs_pkg::bfs_tmode_t  tmode;
   logic [N_EXTRA-1:0]   xen;
   logic                 mode_trig;
   logic                 trig_any;
   logic                 trig_rise;

   assign scheme = bfs_pkg::bfs_scheme_t'(ctrl_r[`BFS_CTRL_SCHEME_LSB +: 2]);
   assign tmode  = bfs_pkg::bfs_tmode_t'(ctrl_r[`BFS_CTRL_TMODE_LSB +: 2]);
   assign xen    = ctrl_r[`BFS_CTRL_XEN_LSB +: N_EXTRA];

   always_comb begin
      unique case (tmode)  // [R11]
         bfs_pkg::all_trip_commands:      mode_trig = ext_trip_cmd | cur_trip_cmd | oth_trip_cmd;
         bfs_pkg::external_trip_commands: mode_trig = ext_trip_cmd;
         bfs_pkg::current_trip_commands:  mode_trig = cur_trip_cmd;
         bfs_pkg::no_trip_commands:       mode_trig = 1'b0;
      endcase
   end

   assign trig_any  = mode_trig | (|(extra_trigger_input & xen));  // [R12]
   assign trig_rise = trig_any && !trig_prev_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trig_prev_r <= 1'b0;
      end else begin
         trig_prev_r <= trig_any;
      end
   end

   // ****************
   // Open detection per scheme
   // ****************
   logic cur_low;
   logic opened;

   assign cur_low = meas_current < thresh_r;

   always_comb begin
      // Combined: either open indication clears
      case (scheme)  // [R6]
         bfs_pkg::position_based_scheme: opened = pos_open;            // [R2]
         bfs_pkg::combined_scheme:       opened = cur_low | pos_open;  // [R3]
         default:                        opened = cur_low;             // [R1]
      endcase
   end

   // ****************
   // Supervision timer and state machine
   // ****************
   logic start;
   logic tick;
   logic expire;

   assign start  = state_r == bfs_pkg::st_standby && trig_rise;  // [R16]
   assign expire = tick && tcount_r >= time_r;

   bfs_tick_gen #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .aclk    (aclk),
      .aresetn (aresetn),
      .restart (start),
      .tick    (tick)
   );

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         bfs_pkg::st_standby: begin
            if (start) begin
               state_nxt = bfs_pkg::st_running;
            end
         end
         bfs_pkg::st_running: begin
            // Timer ignores trigger level
            if (opened) begin  // [R4] [R6]
               state_nxt = trig_any ? bfs_pkg::st_rejected : bfs_pkg::st_standby;  // [R7]
            end else if (expire) begin
               state_nxt = bfs_pkg::st_tripped;  // [R5]
            end
         end
         bfs_pkg::st_rejected: begin
            if (!trig_any) begin
               state_nxt = bfs_pkg::st_standby;  // [R8]
            end
         end
         bfs_pkg::st_tripped: begin
            if (!trig_any) begin
               state_nxt = bfs_pkg::st_standby;
            end
         end
         default: state_nxt = bfs_pkg::st_standby;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= bfs_pkg::st_standby;  // [R15]
      end else begin
         state_r <= state_nxt;
      end
   end

   // Saturates, cannot wrap
   always_ff @(posedge aclk) begin
      if (!aresetn || start || state_r != bfs_pkg::st_running) begin
         tcount_r <= 16'h0001;  // [R15]
      end else if (tick && tcount_r != 16'hFFFF) begin
         tcount_r <= tcount_r + 16'h0001;  // [R15]
      end
   end

   logic trip_evt;
   assign trip_evt = state_r == bfs_pkg::st_running && state_nxt == bfs_pkg::st_tripped;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         failure_trip_r <= 1'b0;  // [R15]
      end else begin
         failure_trip_r <= state_nxt == bfs_pkg::st_tripped;  // [R5]
      end
   end

   // Trip wins over same-cycle acknowledge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         failure_lock_r <= 1'b0;  // [R15]
      end else if (trip_evt) begin
         failure_lock_r <= 1'b1;  // [R9]
      end else if (wr_ack) begin
         failure_lock_r <= 1'b0;  // [R9]
      end
   end

   assign failure_trip = failure_trip_r;  // [R14]
   assign failure_lock = failure_lock_r;  // [R10]

   // ****************
   // Interrupts
   // ****************
   logic [3:0] irq_evt;
   assign irq_evt[`BFS_IRQ_TRIP_BIT]   = trip_evt;
   assign irq_evt[`BFS_IRQ_REJECT_BIT] = state_r == bfs_pkg::st_running
                                         && state_nxt == bfs_pkg::st_rejected;
   assign irq_evt[`BFS_IRQ_OPEN_BIT]   = state_r == bfs_pkg::st_running && opened;
   assign irq_evt[`BFS_IRQ_START_BIT]  = start;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_r <= 4'h0;
      end else begin
         irq_stat_r <= (irq_stat_r & ~(wr_clr ? wr_data[3:0] : 4'h0)) | irq_evt;
      end
   end

   assign irq = |(irq_stat_r & irq_en_r);

   // ****************
   // AXI4-Lite read channel
   // ****************
   logic [31:0] rd_val;

   always_comb begin
      case (s_axi_araddr)
         `BFS_OFF_CTRL:     rd_val = {25'h0, ctrl_r};
         `BFS_OFF_TIME:     rd_val = {16'h0, time_r};
         `BFS_OFF_THRESH:   rd_val = 32'(thresh_r);
         `BFS_OFF_STATUS:   rd_val = {24'h0, trig_any, failure_lock_r, failure_trip_r, 1'b0, state_r};
         `BFS_OFF_IRQ_STAT: rd_val = {28'h0, irq_stat_r};
         `BFS_OFF_IRQ_EN:   rd_val = {28'h0, irq_en_r};
         default:           rd_val = 32'h00000000;
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_val;
         s_axi_rresp  <= addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// ==== verilog/bfs_params.svh ====
// Offsets, fields, resets and timing of the supervisor
`ifndef BFS_PARAMS_SVH
`define BFS_PARAMS_SVH

// ****************
// Register byte offsets
// ****************
`define BFS_OFF_CTRL      8'h00
`define BFS_OFF_TIME      8'h04
`define BFS_OFF_THRESH    8'h08
`define BFS_OFF_STATUS    8'h0C
`define BFS_OFF_ACK       8'h10
`define BFS_OFF_IRQ_STAT  8'h14
`define BFS_OFF_IRQ_CLR   8'h18
`define BFS_OFF_IRQ_EN    8'h1C

// ****************
// Field positions
// ****************
`define BFS_CTRL_SCHEME_LSB  0
`define BFS_CTRL_TMODE_LSB   2
`define BFS_CTRL_XEN_LSB     4
`define BFS_IRQ_TRIP_BIT     0
`define BFS_IRQ_REJECT_BIT   1
`define BFS_IRQ_OPEN_BIT     2
`define BFS_IRQ_START_BIT    3

// ****************
// Reset values
// ****************
`define BFS_CTRL_RST    7'h00
`define BFS_TIME_RST    16'h0064
`define BFS_THRESH_RST  16'h0100
`define BFS_IRQ_EN_RST  4'h0

// ****************
// Timing
// ****************
`define BFS_CLK_PERIOD_NS  100
`define BFS_TICK_NS        1000000
`define BFS_TICK_CYCLES    (`BFS_TICK_NS / `BFS_CLK_PERIOD_NS)

`endif

// ==== verilog/bfs_pkg.sv ====
// Types shared by the breaker failure supervisor
package bfs_pkg;

   // ****************
   // Supervision schemes and trigger modes
   // ****************
   typedef enum logic [1:0] {
      current_based_scheme  = 2'h0,
      position_based_scheme = 2'h1,
      combined_scheme       = 2'h2
   } bfs_scheme_t;

   typedef enum logic [1:0] {
      all_trip_commands      = 2'h0,
      external_trip_commands = 2'h1,
      current_trip_commands  = 2'h2,
      no_trip_commands       = 2'h3
   } bfs_tmode_t;

   // ****************
   // Supervisor states, one-hot
   // ****************
   typedef enum logic [3:0] {
      st_standby  = 4'h1,
      st_running  = 4'h2,
      st_rejected = 4'h4,
      st_tripped  = 4'h8
   } bfs_state_t;

endpackage

// ==== verilog/bfs_tick_gen.sv ====
// Fixed-rate timebase for the supervision timer
`timescale 1ns/100ps
module bfs_tick_gen #(
   parameter int TICK_CYCLES = 10000
) (
   input  wire logic aclk,     // System clock
   input  wire logic aresetn,  // Synchronous reset, active low
   input  wire logic restart,  // Realign the tick phase
   output logic      tick      // One-cycle pulse per period
);

   localparam int CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
   localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

   logic [CW-1:0] cnt_r;

   // Restart gives a full first period
   always_ff @(posedge aclk) begin
      if (!aresetn || restart || cnt_r == LAST) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + CW'(1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick <= 1'b0;
      end else begin
         tick <= !restart && cnt_r == LAST;
      end
   end

endmodule

// ==== tb/bfs_supervisor_properties.sv ====
// Port-level checker for the breaker failure supervisor
`timescale 1ns/100ps
module bfs_supervisor_properties #(
   parameter int N_EXTRA     = 3,
   parameter int CUR_W       = 16
) (
   input wire logic               aclk,                // Clock
   input wire logic               aresetn,             // Reset, low
   input wire logic               s_axi_awvalid,       // AW valid
   input wire logic               s_axi_awready,       // AW ready
   input wire logic               s_axi_wvalid,        // W valid
   input wire logic               s_axi_wready,        // W ready
   input wire logic [1:0]         s_axi_bresp,         // B response
   input wire logic               s_axi_bvalid,        // B valid
   input wire logic               s_axi_bready,        // B ready
   input wire logic               s_axi_arvalid,       // AR valid
   input wire logic               s_axi_arready,       // AR ready
   input wire logic [1:0]         s_axi_rresp,         // R response
   input wire logic               s_axi_rvalid,        // R valid
   input wire logic               s_axi_rready,        // R ready
   input wire logic               ext_trip_cmd,        // External trips
   input wire logic               cur_trip_cmd,        // Current trips
   input wire logic               oth_trip_cmd,        // Other trips
   input wire logic [N_EXTRA-1:0] extra_trigger_input, // Extra triggers
   input wire logic [CUR_W-1:0]   meas_current,        // Current
   input wire logic               pos_open,            // Open indication
   input wire logic               failure_trip,        // Backup trip
   input wire logic               failure_lock         // Lock
);
   logic any_trig;
   assign any_trig = ext_trip_cmd | cur_trip_cmd | oth_trip_cmd | (|extra_trigger_input);

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ****************
   // Supervision
   // ****************
   AST_RESET_CLEAR: assert property ($rose(aresetn) |-> !failure_trip && !failure_lock)
      else $error("set after reset");
   AST_LOCK_WITH_TRIP: assert property ($rose(failure_trip) |-> failure_lock)
      else $error("no lock");
   AST_LOCK_SOURCE: assert property ($rose(failure_lock) |-> $rose(failure_trip))
      else $error("lock alone");
   AST_LOCK_HOLD: assert property (failure_lock && !s_axi_awvalid && !s_axi_wvalid |=> failure_lock)
      else $error("lock dropped");
   AST_TRIP_DROP: assert property (failure_trip && !any_trig |=> !failure_trip)
      else $error("trip held");
   // Open on both indications for two cycles
   AST_TRIP_OPEN: assert property ($rose(failure_trip) |-> !($past(pos_open) && $past(pos_open, 2)
      && $past(meas_current) == 0 && $past(meas_current, 2) == 0))
      else $error("trip while open");

   // ****************
   // Register bus
   // ****************
   AST_B_STAND: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("b not held");
   AST_R_STAND: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp))
      else $error("r not held");
   AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   AST_W_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready && !(s_axi_rvalid
      && s_axi_arready))
      else $error("taken during response");

   COV_TRIP: cover property ($rose(failure_trip));
   COV_ACK: cover property ($fell(failure_lock));
   COV_BAD_WR: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind bfs_supervisor bfs_supervisor_properties #(.N_EXTRA(N_EXTRA), .CUR_W(CUR_W)) u_props (.*);

// ==== tb/bfs_breaker_model.sv ====
// Behavioural monitored breaker with its upstream trip path
`timescale 1ns/100ps
module bfs_breaker_model #(
   parameter int          OPEN_DLY = 12,       // Close-open time, cycles
   parameter logic [15:0] LOAD     = 16'h0400  // Load current when closed
) (
   input  wire logic       aclk,          // System clock
   input  wire logic       open_cmd,      // Held high to open the breaker
   input  wire logic       close_cmd,     // Closes both breakers
   input  wire logic       load_on,       // Load present
   input  wire logic [1:0] pos_fault,     // [1] indicator stuck, [0] its level
   input  wire logic       failure_trip,  // Backup trip
   input  wire logic       failure_lock,  // Close inhibit
   output logic [15:0]     meas_current,  // Measured current
   output logic            pos_open,      // Position indication
   output logic            upstream_open  // Upstream breaker open
);
   int   dly_r = 0;
   logic closed_r = 1'b1;
   logic up_r = 1'b0;

   always_ff @(posedge aclk) begin
      if (close_cmd && !failure_lock) begin
         closed_r <= 1'b1;
         up_r <= 1'b0;
         dly_r <= 0;
      end else begin
         if (failure_trip) begin
            up_r <= 1'b1;
         end
         if (open_cmd && closed_r) begin
            dly_r <= dly_r + 1;
         end
         if (dly_r == OPEN_DLY) begin
            closed_r <= 1'b0;
         end
      end
   end

   assign upstream_open = up_r;
   assign meas_current = (closed_r && !up_r && load_on) ? LOAD : 16'h0000;
   // A faulty indicator may lie in either direction
   assign pos_open = pos_fault[1] ? pos_fault[0] : !closed_r;
endmodule

// ==== tb/bfs_supervisor_bench.sv ====
// Self-checking bench for the breaker failure supervisor
`timescale 1ns/100ps
`include "bfs_params.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
   $display("BAD %0t got %0h exp %0h", $time, got, exp); end end
module bfs_supervisor_bench;
   localparam int TK = 4;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, pos_fault = 2'h0;
   logic        ext_trip_cmd = 0, cur_trip_cmd = 0, oth_trip_cmd = 0;
   logic [2:0]  extra_trigger_input = 3'h0;
   logic [15:0] meas_current;
   logic        pos_open, failure_trip, failure_lock, irq, upstream_open;
   logic        open_cmd = 0, close_cmd = 0, load_on = 1;
   int          num_errors = 0, tests_run = 0;

   always #50 aclk = ~aclk;

   bfs_supervisor #(.TICK_CYCLES(TK)) u_dut (.*);
   bfs_breaker_model u_brk (.aclk, .open_cmd, .close_cmd, .load_on, .pos_fault, .failure_trip,
      .failure_lock, .meas_current, .pos_open, .upstream_open);

   // ****************
   // Tasks
   // ****************
   task automatic stop_test();
      if (num_errors == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic guard(input int n);
      if (n >= 60) begin
         num_errors++;
         stop_test();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic aw, w, b;
      b = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 60 && !b; n++) begin
         @(negedge aclk);
         {aw, w, b} = {s_axi_awready === 1'b1, s_axi_wready === 1'b1, s_axi_bvalid === 1'b1};
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      guard(n);
      `CHK(s_axi_bresp, er)
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      int n;
      logic ar, b;
      b = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 60 && !b; n++) begin
         @(negedge aclk);
         {ar, b, d} = {s_axi_arready === 1'b1, s_axi_rvalid === 1'b1, s_axi_rdata};
         @(posedge aclk);
         if (ar) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      guard(n);
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic [31:0] d;
      rd(a, d);
      `CHK(d, ed)
      `CHK(s_axi_rresp, er)
   endtask

   // Current trip pulse or hold; trip expected near TIME ticks
   task automatic run(input logic [31:0] ctrl, input int hold, input logic exp);
      int n;
      wr(`BFS_OFF_CTRL, ctrl, 2'h0);
      @(posedge aclk);
      cur_trip_cmd <= 1'b1;
      for (n = 1; n <= 40; n++) begin
         @(posedge aclk);
         if (n == hold) cur_trip_cmd <= 1'b0;
         @(negedge aclk);
         if (failure_trip === 1'b1) break;
      end
      `CHK(n <= 40, exp)
      if (n <= 40) begin
         `CHK(failure_lock, 1'b1)
         `CHK(n >= 5 * TK + 1 && n <= 5 * TK + 5, 1'b1)
      end
   endtask

   task automatic tidy();
      @(posedge aclk);
      cur_trip_cmd <= 1'b0;
      open_cmd <= 1'b0;
      pos_fault <= 2'h0;
      wr(`BFS_OFF_ACK, 32'h1, 2'h0);
      wr(`BFS_OFF_IRQ_CLR, 32'hF, 2'h0);
      close_cmd <= 1'b1;
      @(posedge aclk);
      close_cmd <= 1'b0;
   endtask

   // ****************
   // Main sequence
   // ****************
   initial begin
      int          m, c;
      logic [31:0] d;
      logic        exp;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rc(`BFS_OFF_CTRL, 32'h0, 2'h0);
      rc(`BFS_OFF_TIME, 32'h64, 2'h0);
      rc(`BFS_OFF_THRESH, 32'h100, 2'h0);
      rc(`BFS_OFF_STATUS, 32'h1, 2'h0);
      rc(`BFS_OFF_IRQ_EN, 32'h0, 2'h0);
      rc(8'h20, 32'h0, 2'h2);
      wr(8'h20, 32'hFFFF_FFFF, 2'h2);
      rc(`BFS_OFF_CTRL, 32'h0, 2'h0);
      wr(`BFS_OFF_TIME, 32'h5, 2'h0);
      wr(`BFS_OFF_IRQ_EN, 32'hF, 2'h0);

      // Stuck breaker, trigger gone long before expiry
      run(32'h0, 2, 1'b1);
      repeat (10) @(posedge aclk);
      `CHK(failure_lock, 1'b1)
      `CHK(irq, 1'b1)
      rc(`BFS_OFF_IRQ_STAT, 32'h9, 2'h0);
      wr(`BFS_OFF_IRQ_EN, 32'h0, 2'h0);
      `CHK(irq, 1'b0)
      wr(`BFS_OFF_IRQ_EN, 32'hF, 2'h0);
      close_cmd <= 1'b1;
      @(posedge aclk);
      close_cmd <= 1'b0;
      @(posedge aclk);
      `CHK(upstream_open, 1'b1)
      wr(`BFS_OFF_ACK, 32'h1, 2'h0);
      `CHK(failure_lock, 1'b0)
      wr(`BFS_OFF_IRQ_CLR, 32'hF, 2'h0);
      `CHK(irq, 1'b0)
      tidy();

      // Breaker opens in time while the trigger stays up
      open_cmd <= 1'b1;
      run(32'h0, 100, 1'b0);
      rc(`BFS_OFF_STATUS, 32'h84, 2'h0);
      close_cmd <= 1'b1;
      open_cmd <= 1'b0;
      @(posedge aclk);
      close_cmd <= 1'b0;
      repeat (30) @(posedge aclk);
      `CHK(failure_trip, 1'b0)
      rc(`BFS_OFF_STATUS, 32'h84, 2'h0);
      cur_trip_cmd <= 1'b0;
      rc(`BFS_OFF_STATUS, 32'h1, 2'h0);
      tidy();

      // Position scheme ignores the falling current; combined scheme opens on either indication
      open_cmd <= 1'b1;
      pos_fault <= 2'h2;
      run(32'h1, 2, 1'b1);
      tidy();
      pos_fault <= 2'h3;
      run(32'h2, 100, 1'b0);
      tidy();
      open_cmd <= 1'b1;
      pos_fault <= 2'h2;
      run(32'h2, 100, 1'b0);
      tidy();
      run(32'h2, 2, 1'b1);
      tidy();

      // All trigger modes against each trip command and extra trigger 0, enabled and masked
      open_cmd <= 1'b1;
      repeat (20) @(posedge aclk);
      for (m = 0; m < 4; m++) begin
         for (c = 0; c < 5; c++) begin
            wr(`BFS_OFF_CTRL, 32'(m << 2) | ((c == 4) ? 32'h0 : 32'h10), 2'h0);
            wr(`BFS_OFF_IRQ_CLR, 32'hF, 2'h0);
            ext_trip_cmd <= (c == 0);
            cur_trip_cmd <= (c == 1);
            oth_trip_cmd <= (c == 2);
            extra_trigger_input <= {2'h0, c >= 3};
            repeat (3) @(posedge aclk);
            ext_trip_cmd <= 1'b0;
            cur_trip_cmd <= 1'b0;
            oth_trip_cmd <= 1'b0;
            extra_trigger_input <= 3'h0;
            rd(`BFS_OFF_IRQ_STAT, d);
            exp = (c == 3) || (c == 0 && m < 2) || (c == 1 && (m == 0 || m == 2)) || (c == 2 && m == 0);
            `CHK(d[3], exp)
         end
      end
      stop_test();
   end
endmodule
